// [logic/paged_port_and_output_routing.v]
// paged serial register port with lockout, status and output routing
// assumes the serial front end delivers one-cycle access strobes in ref_clk domain
`timescale 1ns/1ps
`include "page_port_consts.vh"

module paged_port_and_output_routing (
  input  wire        ref_clk,
  input  wire        reset_n,
  input  wire        acc_wr,
  input  wire        acc_rd,
  input  wire [6:0]  acc_addr,
  input  wire [7:0]  acc_wdata,
  input  wire        acc_fail,
  input  wire        remap,
  output reg  [7:0]  acc_rdata,
  output reg         acc_done,
  output reg  [1:0]  pair_source,
  output reg         fast_clock_output_ten_src_valid,
  output reg  [14:0] internal_addr
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage; lock bits 7:1 are the lockout field, bit 0 the status
  reg  [7:0]  route_q;
  reg  [7:0]  route_d;
  reg  [7:0]  cal_q;
  reg  [7:0]  cal_d;
  reg  [7:0]  lock_q;
  reg  [7:0]  lock_d;
  reg  [7:0]  page_q;
  reg  [7:0]  page_d;
  reg  [7:0]  rd_d;
  reg         page_bad;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  wire [14:0] full_addr;
  wire [11:0] page_sel_addr;
  wire [14:0] route_addr;
  wire [14:0] cal_addr;
  wire [14:0] lock_addr;
  wire        hit_route;
  wire        hit_cal;
  wire        hit_lock;
  wire        hit_page;
  wire [3:0]  rd_sel;
  wire        locked;
  wire        acc;
  wire        wr_ok;
  wire        wr_open;
  wire        fail_now;
  wire [1:0]  src_d;

  assign full_addr     = {page_q, acc_addr};
  assign page_sel_addr = `ADDR_PAGE_SEL;
  assign route_addr    = {3'h0, `ADDR_ROUTE_SEL};
  assign cal_addr      = {3'h0, `ADDR_CAL_ALIGN};
  assign lock_addr     = {3'h0, `ADDR_PORT_LOCK};

  assign hit_route     = (full_addr == route_addr);
  assign hit_cal       = (full_addr == cal_addr);
  assign hit_lock      = (full_addr == lock_addr);
  // page select answers on every page, so software can move back whenever the lockout field is clear
  assign hit_page      = (acc_addr == page_sel_addr[6:0]);
  assign rd_sel        = {hit_page, hit_lock, hit_cal, hit_route};

  assign locked        = |lock_q[`LOCK_HI:`LOCK_LO];
  assign acc           = acc_wr | acc_rd;
  // a write the front end flags as failed changes no register except the status bit
  assign wr_ok         = acc_wr & ~acc_fail;
  assign wr_open       = wr_ok & ~locked;
  assign fail_now      = acc_fail | page_bad;

  ////////////////////////////////////////////////////////////////////////////
  // reserved or out-of-range pages reach only page select; the access counts as failed
  always @* begin
    page_bad = 1'b0;
    if (page_q > `PAGE_LAST) begin
      page_bad = 1'b1;
    end else begin
      case (page_q)
        `PAGE_RSV_A: page_bad = 1'b1;
        `PAGE_RSV_B: page_bad = 1'b1;
        default:     page_bad = 1'b0;
      endcase
    end
  end

  route_source_mux u_mux (
    .output_pair_source_select (route_q[`ROUTE_BIT]),
    .remap                     (remap),
    .source_code               (src_d)
  );

  ////////////////////////////////////////////////////////////////////////////
  // route keeps only its one defined bit; reserved bits read back 0
  always @* begin
    route_d = route_q;
    if (wr_open && hit_route) begin
      route_d = acc_wdata & `ROUTE_MASK;
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      route_q <= `RST_ROUTE_SEL;
    end else begin
      route_q <= route_d;
    end
  end

  // calibration alignment keeps only bit 0
  always @* begin
    cal_d = cal_q;
    if (wr_open && hit_cal) begin
      cal_d = acc_wdata & `CAL_MASK;
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_q <= `RST_CAL_ALIGN;
    end else begin
      cal_q <= cal_d;
    end
  end

  // lock field stays writable under lockout, otherwise it could never be released
  always @* begin
    lock_d = lock_q;
    if (wr_ok && hit_lock) begin
      lock_d[`LOCK_HI:`LOCK_LO] = acc_wdata[`LOCK_HI:`LOCK_LO];
    end
    // every access rewrites the status; software writes to it are dropped
    if (acc) begin
      lock_d[`STATUS_BIT] = fail_now;
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_q <= `RST_PORT_LOCK;
    end else begin
      lock_q <= lock_d;
    end
  end

  // page select obeys the lockout like the route and calibration registers
  always @* begin
    page_d = page_q;
    if (wr_open && hit_page) begin
      page_d = acc_wdata;
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      page_q <= `RST_PAGE_SEL;
    end else begin
      page_q <= page_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data selection; unmapped addresses read 0
  always @* begin
    rd_d = 8'h00;
    case (rd_sel)
      4'b0001: rd_d = route_q;
      4'b0010: rd_d = cal_q;
      4'b0100: rd_d = lock_q;
      4'b1000: rd_d = page_q;
      default: rd_d = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // done pulse follows every taken strobe by one clock
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_done <= 1'b0;
    end else begin
      acc_done <= acc;
    end
  end

  // read data holds until the next read so a slow host can still pick it up
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_rdata <= 8'h00;
    end else if (acc_rd) begin
      acc_rdata <= rd_d;
    end
  end

  // address of the last access, page included
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      internal_addr <= 15'h0000;
    end else if (acc) begin
      internal_addr <= full_addr;
    end
  end

  // source code lags the route bit and remap by one clock
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pair_source <= `SRC_S3_DIV_B;
    end else begin
      pair_source <= src_d;
    end
  end

  // flag rises at the first edge after reset and stays
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fast_clock_output_ten_src_valid <= 1'b0;
    end else begin
      fast_clock_output_ten_src_valid <= 1'b1;
    end
  end

endmodule

// [shared/page_port_consts.vh]
// constants for the paged port and output routing register bank
// assumes inclusion by bare name from the design files
// Behaviour
// - with remap clear, route bit 0 picks synthesizer three divider B and 1 picks divider A.
// - with remap set, route bit 0 picks synthesizer two divider D and 1 picks divider C.
// - while the lockout field is nonzero every other port register ignores writes.
// - a failed host access sets the status bit; the status bit reads 0 after a good access.
`ifndef PAGE_PORT_CONSTS_VH
`define PAGE_PORT_CONSTS_VH

`define ADDR_ROUTE_SEL      12'h255
`define ADDR_CAL_ALIGN      12'h25c
`define ADDR_PORT_LOCK      12'h27e
`define ADDR_PAGE_SEL       12'h27f

`define RST_ROUTE_SEL       8'h00
`define RST_CAL_ALIGN       8'h01
`define RST_PORT_LOCK       8'h00
`define RST_PAGE_SEL        8'h00

`define ROUTE_BIT           2
`define ROUTE_MASK          8'h04
`define CAL_MASK            8'h01
`define LOCK_HI             7
`define LOCK_LO             1
`define STATUS_BIT          0

`define PAGE_RSV_A          8'h07
`define PAGE_RSV_B          8'h09
`define PAGE_LAST           8'h0c

`define SRC_S3_DIV_B        2'h0
`define SRC_S3_DIV_A        2'h1
`define SRC_S2_DIV_D        2'h2
`define SRC_S2_DIV_C        2'h3

`endif

// [logic/route_source_mux.v]
// source selection for output pair ten/eleven
// assumes route and remap are stable register levels
`timescale 1ns/1ps
`include "page_port_consts.vh"

module route_source_mux (
  input  wire       output_pair_source_select,
  input  wire       remap,
  output reg  [1:0] source_code
);

  always @* begin
    case ({remap, output_pair_source_select})
      2'b00:   source_code = `SRC_S3_DIV_B;
      2'b01:   source_code = `SRC_S3_DIV_A;
      2'b10:   source_code = `SRC_S2_DIV_D;
      default: source_code = `SRC_S2_DIV_C;
    endcase
  end

endmodule

// [bench/paged_port_and_output_routing_properties.sv]
// port-side checks for the paged register port
// assumes one-cycle strobes on ref_clk
`timescale 1ns/1ps
module paged_port_and_output_routing_properties (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        acc_wr,
  input wire logic        acc_rd,
  input wire logic        acc_fail,
  input wire logic        remap,
  input wire logic        acc_done,
  input wire logic        fast_clock_output_ten_src_valid,
  input wire logic [6:0]  acc_addr,
  input wire logic [7:0]  acc_wdata,
  input wire logic [7:0]  acc_rdata,
  input wire logic [1:0]  pair_source,
  input wire logic [14:0] internal_addr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_strobe_done: assert property ((acc_wr || acc_rd) |=> acc_done) else $error("no done");
  a_idle_quiet: assert property (!(acc_wr || acc_rd) |=> !acc_done) else $error("stray done");
  a_addr_join: assert property ((acc_wr || acc_rd) |=>
    internal_addr[6:0] == $past(acc_addr)) else $error("bad address");
  a_remap_clear: assert property (!remap |=> !pair_source[1]) else $error("bad src");
  a_remap_set: assert property (remap ##1 remap |-> pair_source[1]) else $error("bad src");
  a_rdata_hold: assert property (!acc_rd |=> $stable(acc_rdata)) else $error("rdata moved");
  cover property (acc_wr && remap);
  cover property (acc_wr && acc_fail);
  cover property (acc_rd ##1 acc_done);
endmodule
bind paged_port_and_output_routing paged_port_and_output_routing_properties chk_i (.*);

// [bench/host_port.sv]
// host model driving the serial access strobes
// assumes the one-cycle answer of the port
`timescale 1ns/1ps
module host_port (
  input  wire        ref_clk,
  output logic       acc_wr,
  output logic       acc_rd,
  output logic       acc_fail,
  output logic [6:0] acc_addr,
  output logic [7:0] acc_wdata
);
  initial {acc_wr, acc_rd, acc_fail, acc_addr, acc_wdata} = '0;
  task automatic xfer(input logic w, f, input logic [6:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {acc_wr, acc_rd, acc_fail, acc_addr, acc_wdata} = {w, !w, f, a, d};
    @(negedge ref_clk);
    {acc_wr, acc_rd, acc_fail} = '0;
    // released lines carry junk, not the old value
    acc_addr = ~a;
    acc_wdata = ~d;
  endtask
endmodule

// [bench/paged_port_and_output_routing_tb.sv]
// bench for the paged register port and routing
// assumes host_port as the serial host
`timescale 1ns/1ps
module paged_port_and_output_routing_tb;
  logic ref_clk = 0, reset_n = 0, remap = 0, acc_wr, acc_rd, acc_fail, acc_done;
  logic fast_clock_output_ten_src_valid;
  logic [6:0] acc_addr;
  logic [7:0] acc_wdata, acc_rdata;
  logic [1:0] pair_source;
  logic [14:0] internal_addr;
  int err_count = 0, compares = 0;
  paged_port_and_output_routing dut (.*);
  host_port h (.*);
  task automatic chk(input logic [14:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    h.xfer(0, 0, a, 8'h00);
    chk(acc_rdata, e);
  endtask
  task automatic complete_run;
    $display("compares=%0d errors=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial forever #5 ref_clk = ~ref_clk;
  initial begin
    #20000;
    err_count++;
    complete_run;
  end
  initial begin
    repeat (6) @(negedge ref_clk);
    chk(fast_clock_output_ten_src_valid, 1'b0);
    chk(pair_source, 2'h0);
    reset_n = 1;
    h.xfer(1, 0, 7'h7f, 8'h04);
    chk(internal_addr, 15'h07f);
    chk(fast_clock_output_ten_src_valid, 1'b1);
    rd(7'h55, 8'h00);
    rd(7'h5c, 8'h01);
    rd(7'h7e, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      remap = i[1];
      h.xfer(1, 0, 7'h55, {5'h00, i[0], 2'h0});
      @(negedge ref_clk);
      chk(pair_source, i[1:0]);
    end
    h.xfer(1, 0, 7'h7e, 8'h02);
    h.xfer(1, 0, 7'h55, 8'h00);
    rd(7'h55, 8'h04);
    h.xfer(1, 0, 7'h7e, 8'h00);
    h.xfer(1, 1, 7'h55, 8'h00);
    rd(7'h7e, 8'h01);
    rd(7'h55, 8'h04);
    h.xfer(1, 0, 7'h7f, 8'h07);
    rd(7'h7f, 8'h07);
    h.xfer(1, 0, 7'h7f, 8'h04);
    rd(7'h7e, 8'h01);
    rd(7'h7e, 8'h00);
    h.xfer(1, 0, 7'h7f, 8'h05);
    rd(7'h55, 8'h00);
    chk(internal_addr, 15'h2d5);
    h.xfer(1, 0, 7'h7f, 8'h04);
    h.xfer(1, 0, 7'h55, 8'h00);
    rd(7'h55, 8'h00);
    $display("port test done");
    complete_run;
  end
endmodule
